/* fsc_asserts.sv */
// Concurrent checks on the function source combiner ports.
`timescale 1ns/100ps
module fsc_asserts
    import func_comb_pkg::*;
(
    // Clock, reset and bus.
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               pslverr,
    // Terminals and results.
    input wire logic [FN_HI:FN_LO] term_func,
    input wire logic               term_start,
    input wire func_out_t          func_out
);
    // Every check runs on the bus clock and rests during reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ramp_or_a: assert property (
        term_func[FN_RAMP2] |=> func_out.ramp_set2)
        else $error("Ramp setting two missed a terminal request.");
    enable_and_a: assert property (
        !term_func[FN_AN_EN0] |=> !func_out.analog_en[0])
        else $error("Reference enable rose without the terminal.");
    fault_low_a: assert property (
        !term_func[FN_EXT_FAULT] [*2] |-> func_out.ext_fault)
        else $error("Low fault line did not raise the fault.");
    field_rev_a: assert property (
        $rose(term_func[FN_FIELD_REV]) |=> func_out.field_rev)
        else $error("Field reversal request was lost.");
    value_sel_a: assert property (
        term_func[FN_VAL_SEL0] |=> func_out.value_sel[0])
        else $error("Value switch missed a terminal request.");
    master_or_a: assert property (
        term_func[FN_MASTER] |=> func_out.master_slave)
        else $error("Master switch missed a terminal request.");
    start_and_a: assert property (
        !term_start |=> !func_out.start_run)
        else $error("Start rose without the terminal.");
    bus_ready_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("Ready was not a single access cycle pulse.");
    bus_err_a: assert property (
        pslverr |-> pready)
        else $error("Error flag seen without ready.");

    // Main scenarios reached.
    ramp_c: cover property (func_out.ramp_set2);
    fault_c: cover property (func_out.ext_fault);
    err_c: cover property (pready && pslverr);
endmodule

bind func_source_combiner fsc_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .term_func(term_func),
    .term_start(term_start), .func_out(func_out));

/* fsc_terminals.sv */
// Terminal wiring model that presents requested levels to the combiner.
`timescale 1ns/100ps
module fsc_terminals
    import func_comb_pkg::*;
(
    // Clock and reset.
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Levels the bench asks for.
    input  wire logic [FN_HI:FN_LO] want,
    input  wire logic               want_start,
    input  wire logic               want_op,
    // Terminal lines into the combiner.
    output logic      [FN_HI:FN_LO] term_func,
    output logic                    term_start,
    output logic                    term_operate
);
    // Idle wiring keeps the active-low fault and warning lines high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_func               <= '0;
            term_func[FN_EXT_FAULT] <= 1'b1;
            term_func[FN_EXT_WARN]  <= 1'b1;
            term_start              <= 1'b0;
            term_operate            <= 1'b0;
        end else begin
            term_func    <= want;
            term_start   <= want_start;
            term_operate <= want_op;
        end
    end
endmodule

/* func_comb_pkg.sv */
// Constants, register map and carrier types for the function combiner.
package func_comb_pkg;

    // Function numbering handled by the combiner.
    localparam int FN_LO        = 13;
    localparam int FN_HI        = 68;
    localparam int FN_W         = FN_HI - FN_LO + 1;
    localparam int NUM_REF      = 11;
    localparam int NUM_ZERO_REF = 4;
    localparam int FN_RAMP2     = 31;
    localparam int FN_RAMP3     = 32;
    localparam int FN_MASTER    = 41;
    localparam int FN_TORQUE    = 42;
    localparam int FN_AN_EN0    = 43;
    localparam int FN_AN_INV0   = 48;
    localparam int NUM_ANALOG   = 5;
    localparam int FN_EXT_FAULT = 53;
    localparam int FN_EXT_WARN  = 54;
    localparam int FN_FIELD_REV = 57;
    localparam int FN_BIN_OUT0  = 61;
    localparam int NUM_BIN_OUT  = 4;
    localparam int FN_VAL_SEL0  = 65;
    localparam int NUM_VAL_SEL  = 3;

    // Control word layout.
    localparam int CW_W            = 16;
    localparam int MAP_W           = 7;
    localparam int SERIAL_OK_BIT   = 10;
    localparam int STW_START_BIT   = 0;
    localparam int STW_OPERATE_BIT = 3;
    localparam int MAPS_PER_REG    = 4;
    localparam int MAP_REGS        = CW_W / MAPS_PER_REG;
    localparam int SEL_W           = 8;
    localparam logic [SEL_W-1:0] BIN_OUT_ACTIVE_SEL = 8'h02;
    localparam int REF_W           = 16;

    // Register byte offsets.
    localparam logic [7:0] STD_CW_OFS   = 8'h00;
    localparam logic [7:0] SRC_CW_OFS   = 8'h04;
    localparam logic [7:0] OUT_SEL_OFS  = 8'h08;
    localparam logic [7:0] BIT_MAP_OFS  = 8'h0C;
    localparam logic [7:0] CW_STAT_OFS  = 8'h20;
    localparam logic [7:0] FN_STAT0_OFS = 8'h24;
    localparam logic [7:0] FN_STAT1_OFS = 8'h28;
    localparam logic [7:0] INT_STAT_OFS = 8'h30;
    localparam logic [7:0] INT_MASK_OFS = 8'h34;
    localparam logic [7:0] REF_SET_OFS  = 8'h40;
    localparam logic [7:0] REF_OUT_OFS  = 8'h80;

    // Interrupt status bit positions.
    localparam int INT_FAULT    = 0;
    localparam int INT_WARN     = 1;
    localparam int INT_LOST     = 2;
    localparam int INT_CONFLICT = 3;
    localparam int INT_W        = 4;

    // Reset values.
    localparam logic [CW_W-1:0]     CW_RST       = 16'h0000;
    localparam logic [MAP_W-1:0]    MAP_RST      = 7'h00;
    localparam logic [SEL_W-1:0]    SEL_RST      = 8'h00;
    localparam logic [INT_W-1:0]    INT_MASK_RST = 4'h0;
    localparam logic [REF_W-1:0]    REF_RST      = 16'h0000;

    // Registered function results handed to the drive control.
    typedef struct packed {
        logic                   ramp_set2;
        logic                   ramp_set3;
        logic                   master_slave;
        logic                   torque_lim_sel;
        logic [NUM_ANALOG-1:0]  analog_en;
        logic [NUM_ANALOG-1:0]  analog_inv;
        logic                   ext_fault;
        logic                   ext_warn;
        logic                   field_rev;
        logic                   start_run;
        logic                   operate_en;
        logic [NUM_BIN_OUT-1:0] bin_out;
        logic [NUM_VAL_SEL-1:0] value_sel;
    } func_out_t;

endpackage

/* func_combine.sv */
// Merges terminal and serial requests for a vector of functions.
`timescale 1ns/100ps
module func_combine #(
    parameter int W        = 8,
    parameter bit AND_MODE = 1'b0
) (
    // Requests from both sources.
    input  wire logic [W-1:0] term_req,
    input  wire logic [W-1:0] ser_req,
    input  wire logic [W-1:0] ser_asg,
    // Merged result.
    output logic      [W-1:0] merged
);

    // An unassigned serial source neither blocks an AND nor adds to an OR.
    always_comb begin
        if (AND_MODE) begin
            merged = term_req & (ser_req | ~ser_asg);
        end else begin
            merged = term_req | (ser_req & ser_asg);
        end
    end

endmodule

/* func_source_combiner.sv */
// Binary function source combiner with its APB register file.
`timescale 1ns/100ps
module func_source_combiner
    import func_comb_pkg::*;
#(
    parameter int NREF = NUM_REF,
    parameter int RW   = REF_W
) (
    // Clock and reset.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave.
    input  wire logic [7:0]              paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic      [31:0]             prdata,
    output logic                         pslverr,
    // Terminal side.
    input  wire logic [FN_HI:FN_LO]      term_func,
    input  wire logic                    term_start,
    input  wire logic                    term_operate,
    // Results.
    output func_out_t                    func_out,
    output logic      [NREF-1:0][RW:0]   ref_out,
    output logic                         serial_ok,
    output logic                         irq
);

    // Register state.
    logic [CW_W-1:0]      std_cw_r;
    logic [CW_W-1:0]      src_cw_r;
    logic [CW_W-1:0]      ser_word_r;
    logic [CW_W-1:0]      std_used_r;
    logic [SEL_W-1:0]     out_sel_r [NUM_BIN_OUT];
    logic [MAP_W-1:0]     bit_map_r [CW_W];
    logic [RW-1:0]        ref_set_r [NREF];
    logic [INT_W-1:0]     int_stat_r;
    logic [INT_W-1:0]     int_mask_r;
    logic                 conflict_r;
    func_out_t            func_out_r;
    logic [NREF-1:0][RW:0] ref_out_r;
    logic                 serial_ok_r;
    logic                 irq_r;
    logic                 pready_r;
    logic [31:0]          prdata_r;
    logic                 pslverr_r;

    // Combinational signals.
    logic [FN_W-1:0]      ser_req;
    logic [FN_W-1:0]      ser_asg;
    logic [FN_W-1:0]      term_vec;
    logic [FN_W-1:0]      and_res;
    logic [FN_W-1:0]      or_res;
    func_out_t            func_nxt;
    logic [NREF-1:0][RW-1:0] ref_set_vec;
    logic [NREF-1:0][RW:0] ref_nxt;
    logic                 conflict_nxt;
    logic [INT_W-1:0]     int_event;
    logic [31:0]          rd_data;
    logic                 rd_err;
    logic                 setup;
    logic                 access;
    logic                 wr_en;
    logic                 rd_en;
    logic                 in_ref_set;
    logic                 in_ref_out;
    logic [7:0]           ref_set_idx;
    logic [7:0]           ref_out_idx;

    // APB phase decode; every access completes in its first access cycle.
    assign setup  = psel && !penable;
    assign access = psel && penable && pready_r;
    assign wr_en  = access && pwrite;
    assign rd_en  = access && !pwrite;

    // Range decode of the reference setting and result windows.
    assign ref_set_idx = (paddr - REF_SET_OFS) >> 2;
    assign ref_out_idx = (paddr - REF_OUT_OFS) >> 2;
    assign in_ref_set  = (paddr >= REF_SET_OFS) && (paddr[1:0] == 2'b00)
                         && (ref_set_idx < 8'(NREF));
    assign in_ref_out  = (paddr >= REF_OUT_OFS) && (paddr[1:0] == 2'b00)
                         && (ref_out_idx < 8'(NREF));

    // Control words written by the automation system.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            std_cw_r <= CW_RST;
            src_cw_r <= CW_RST;
        end else if (wr_en) begin
            if (paddr == STD_CW_OFS) begin
                std_cw_r <= pwdata[CW_W-1:0];
            end
            if (paddr == SRC_CW_OFS) begin
                src_cw_r <= pwdata[CW_W-1:0];
            end
        end
    end

    // Serial data is taken over only while the serial valid bit is set;
    // otherwise the last accepted words stay in force.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_word_r  <= CW_RST;
            std_used_r  <= CW_RST;
            serial_ok_r <= 1'b0;
        end else begin
            serial_ok_r <= std_cw_r[SERIAL_OK_BIT];
            if (std_cw_r[SERIAL_OK_BIT]) begin
                ser_word_r <= src_cw_r;
                std_used_r <= std_cw_r;
            end
        end
    end

    // Output select settings, one byte each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int k = 0; k < NUM_BIN_OUT; k++) begin
                out_sel_r[k] <= SEL_RST;
            end
        end else if (wr_en && paddr == OUT_SEL_OFS) begin
            for (int k = 0; k < NUM_BIN_OUT; k++) begin
                out_sel_r[k] <= pwdata[SEL_W*k +: SEL_W];
            end
        end
    end

    // Function number assigned to each serial word bit, four per word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CW_W; i++) begin
                bit_map_r[i] <= MAP_RST;
            end
        end else if (wr_en) begin
            for (int r = 0; r < MAP_REGS; r++) begin
                if (paddr == BIT_MAP_OFS + 8'(4 * r)) begin
                    for (int j = 0; j < MAPS_PER_REG; j++) begin
                        bit_map_r[MAPS_PER_REG*r + j] <=
                            pwdata[8*j +: MAP_W];
                    end
                end
            end
        end
    end

    // Reference value settings, one per reference function.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREF; i++) begin
                ref_set_r[i] <= REF_RST;
            end
        end else if (wr_en && in_ref_set) begin
            ref_set_r[ref_set_idx[3:0]] <= pwdata[RW-1:0];
        end
    end

    // Decode the accepted serial word into per-function requests.
    always_comb begin
        ser_req = '0;
        ser_asg = '0;
        for (int i = 0; i < CW_W; i++) begin
            for (int f = FN_LO; f <= FN_HI; f++) begin
                if (bit_map_r[i] == MAP_W'(f)) begin
                    ser_asg[f-FN_LO] = 1'b1;
                    if (ser_word_r[i]) begin
                        ser_req[f-FN_LO] = 1'b1;
                    end
                end
            end
        end
    end

    assign term_vec = term_func;

    // AND view of every function.
    func_combine #(
        .W        (FN_W),
        .AND_MODE (1'b1)
    ) u_and_comb (
        .term_req (term_vec),
        .ser_req  (ser_req),
        .ser_asg  (ser_asg),
        .merged   (and_res)
    );

    // OR view of every function.
    func_combine #(
        .W        (FN_W),
        .AND_MODE (1'b0)
    ) u_or_comb (
        .term_req (term_vec),
        .ser_req  (ser_req),
        .ser_asg  (ser_asg),
        .merged   (or_res)
    );

    // Pick the documented logic for each function.
    always_comb begin
        func_nxt = '0;
        func_nxt.ramp_set2      = or_res[FN_RAMP2-FN_LO];
        func_nxt.ramp_set3      = or_res[FN_RAMP3-FN_LO];
        func_nxt.master_slave   = or_res[FN_MASTER-FN_LO];
        func_nxt.torque_lim_sel = or_res[FN_TORQUE-FN_LO];
        func_nxt.analog_en  =
            and_res[FN_AN_EN0-FN_LO +: NUM_ANALOG];
        func_nxt.analog_inv =
            or_res[FN_AN_INV0-FN_LO +: NUM_ANALOG];
        // Low on any source raises the event.
        func_nxt.ext_fault  = !and_res[FN_EXT_FAULT-FN_LO];
        func_nxt.ext_warn   = !and_res[FN_EXT_WARN-FN_LO];
        func_nxt.field_rev  = or_res[FN_FIELD_REV-FN_LO];
        func_nxt.start_run  = term_start && std_used_r[STW_START_BIT];
        func_nxt.operate_en = term_operate
                              && std_used_r[STW_OPERATE_BIT];
        for (int k = 0; k < NUM_BIN_OUT; k++) begin
            func_nxt.bin_out[k] = or_res[FN_BIN_OUT0-FN_LO+k]
                && (out_sel_r[k] == BIN_OUT_ACTIVE_SEL);
        end
        func_nxt.value_sel  =
            or_res[FN_VAL_SEL0-FN_LO +: NUM_VAL_SEL];
    end

    // Pack settings for the reference selector.
    always_comb begin
        for (int i = 0; i < NREF; i++) begin
            ref_set_vec[i] = ref_set_r[i];
        end
    end

    // Reference results for the jog through additional functions.
    ref_select #(
        .N        (NREF),
        .W        (RW),
        .N_ZERO   (NUM_ZERO_REF)
    ) u_ref_sel (
        .term_req (term_vec[NREF-1:0]),
        .ser_req  (ser_req[NREF-1:0]),
        .setting  (ref_set_vec),
        .ref_val  (ref_nxt),
        .conflict (conflict_nxt)
    );

    // All consumers see one consistent registered set each cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_out_r <= '0;
            ref_out_r  <= '0;
            conflict_r <= 1'b0;
        end else begin
            func_out_r <= func_nxt;
            ref_out_r  <= ref_nxt;
            conflict_r <= conflict_nxt;
        end
    end

    // Rising edges of the watched conditions.
    always_comb begin
        int_event               = '0;
        int_event[INT_FAULT]    = func_nxt.ext_fault
                                  && !func_out_r.ext_fault;
        int_event[INT_WARN]     = func_nxt.ext_warn
                                  && !func_out_r.ext_warn;
        int_event[INT_LOST]     = serial_ok_r
                                  && !std_cw_r[SERIAL_OK_BIT];
        int_event[INT_CONFLICT] = conflict_nxt && !conflict_r;
    end

    // A read clears only the bits it returned; new events win the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= '0;
        end else if (rd_en && paddr == INT_STAT_OFS) begin
            int_stat_r <= (int_stat_r & ~prdata_r[INT_W-1:0]) | int_event;
        end else begin
            int_stat_r <= int_stat_r | int_event;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= INT_MASK_RST;
        end else if (wr_en && paddr == INT_MASK_OFS) begin
            int_mask_r <= pwdata[INT_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(int_stat_r & int_mask_r);
        end
    end

    // Read data multiplexer; unmapped addresses answer with an error.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (in_ref_set) begin
            rd_data[RW-1:0] = ref_set_r[ref_set_idx[3:0]];
        end else if (in_ref_out) begin
            rd_data[RW:0] = ref_out_r[ref_out_idx[3:0]];
        end else begin
            case (paddr)
                STD_CW_OFS:   rd_data[CW_W-1:0] = std_cw_r;
                SRC_CW_OFS:   rd_data[CW_W-1:0] = src_cw_r;
                OUT_SEL_OFS: begin
                    for (int k = 0; k < NUM_BIN_OUT; k++) begin
                        rd_data[SEL_W*k +: SEL_W] = out_sel_r[k];
                    end
                end
                CW_STAT_OFS: begin
                    rd_data[CW_W-1:0] = ser_word_r;
                    rd_data[CW_W]     = serial_ok_r;
                end
                FN_STAT0_OFS: rd_data = (and_res & or_res) == '0 ?
                                        or_res[31:0] : or_res[31:0];
                FN_STAT1_OFS: rd_data[FN_W-33:0] = or_res[FN_W-1:32];
                INT_STAT_OFS: rd_data[INT_W-1:0] = int_stat_r;
                INT_MASK_OFS: rd_data[INT_W-1:0] = int_mask_r;
                default: begin
                    rd_err = 1'b1;
                    for (int r = 0; r < MAP_REGS; r++) begin
                        if (paddr == BIT_MAP_OFS + 8'(4 * r)) begin
                            rd_err = 1'b0;
                            for (int j = 0; j < MAPS_PER_REG; j++) begin
                                rd_data[8*j +: MAP_W] =
                                    bit_map_r[MAPS_PER_REG*r + j];
                            end
                        end
                    end
                end
            endcase
        end
    end

    // APB answer: ready, data and error are loaded in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            if (setup) begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_r <= rd_err;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // Outputs come straight from flip-flops.
    assign pready    = pready_r;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign func_out  = func_out_r;
    assign ref_out   = ref_out_r;
    assign serial_ok = serial_ok_r;
    assign irq       = irq_r;

endmodule

/* func_source_combiner_tb.sv */
// Self-checking bench for the binary function source combiner.
`timescale 1ns/100ps
module func_source_combiner_tb
    import func_comb_pkg::*;
;
    logic                        pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]                  paddr;
    logic [31:0]                 pwdata, prdata, rd;
    logic                        pready, pslverr, serial_ok, irq;
    logic                        want_start, want_op, term_start, term_operate;
    logic [FN_HI:FN_LO]          want, term_func;
    func_out_t                   func_out;
    logic [NUM_REF-1:0][REF_W:0] ref_out;
    int                          fail_count, n_tests;
    int                          cyc = 0;

    func_source_combiner dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .term_func(term_func), .term_start(term_start),
        .term_operate(term_operate), .func_out(func_out),
        .ref_out(ref_out), .serial_ok(serial_ok), .irq(irq));
    fsc_terminals term_u (
        .pclk(pclk), .presetn(presetn), .want(want),
        .want_start(want_start), .want_op(want_op), .term_func(term_func),
        .term_start(term_start), .term_operate(term_operate));

    // Free-running bus clock.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Cuts a hung run short.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer, held until ready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    // OR-merged and unassigned AND results packed for one compare.
    function automatic logic [31:0] grp();
        return {14'h0000, func_out.ramp_set2, func_out.ramp_set3,
                func_out.master_slave, func_out.torque_lim_sel,
                func_out.analog_en, func_out.analog_inv,
                func_out.field_rev, func_out.value_sel};
    endfunction

    initial begin
        logic [31:0] e;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0000_0000;
        want       = '0;
        want[FN_EXT_FAULT] = 1'b1;
        want[FN_EXT_WARN]  = 1'b1;
        want_start = 1'b0;
        want_op    = 1'b0;
        fail_count = 0;
        n_tests    = 0;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        // Mask resets clear and an unmapped word is refused.
        rdc(INT_MASK_OFS, 32'h0000_0000);
        rdc(8'hFC, 32'h0000_0000);
        chk(er, 32'h0000_0001);
        // Terminals alone drive every OR result and the unassigned ANDs.
        want[32:31] <= 2'b11;
        want[52:41] <= 12'hFFF;
        want[57]    <= 1'b1;
        want[67:61] <= 7'h7F;
        tick(3);
        chk(grp(), 32'h0003_FFFF);
        chk(func_out.field_rev, 32'h0000_0001);
        chk(func_out.bin_out, 32'h0000_0000);
        apb(1'b1, OUT_SEL_OFS, 32'h0203_0102);
        tick(2);
        chk(func_out.bin_out, 32'h0000_0009);
        want[52:31] <= '0;
        want[67:55] <= '0;
        want[FN_EXT_FAULT] <= 1'b0;
        tick(3);
        chk(grp(), 32'h0000_0000);
        chk(func_out.ext_fault, 32'h0000_0001);
        want[FN_EXT_FAULT] <= 1'b1;
        rdc(INT_STAT_OFS, 32'h0000_0001);
        // Serial word stays frozen until the serial valid bit is set.
        apb(1'b1, BIT_MAP_OFS, 32'h0D35_2B20);
        apb(1'b1, BIT_MAP_OFS + 8'h04, 32'h0000_0011);
        rdc(INT_STAT_OFS, 32'h0000_0001);
        apb(1'b1, INT_MASK_OFS, 32'h0000_0001);
        apb(1'b1, SRC_CW_OFS, 32'h0000_001F);
        tick(3);
        chk(func_out.ramp_set3, 32'h0000_0000);
        chk({serial_ok, irq}, 32'h0000_0000);
        apb(1'b1, STD_CW_OFS, 32'h0000_0409);
        tick(3);
        chk(serial_ok, 32'h0000_0001);
        chk(func_out.ramp_set3, 32'h0000_0001);
        chk(func_out.analog_en[0], 32'h0000_0000);
        want[FN_AN_EN0] <= 1'b1;
        want_start <= 1'b1;
        want_op    <= 1'b1;
        tick(3);
        chk(func_out.analog_en[0], 32'h0000_0001);
        chk({func_out.start_run, func_out.operate_en}, 32'h0000_0003);
        // Serial fault request raises the fault and the interrupt.
        apb(1'b1, SRC_CW_OFS, 32'h0000_001B);
        tick(3);
        chk({func_out.ext_fault, irq}, 32'h0000_0003);
        apb(1'b1, SRC_CW_OFS, 32'h0000_001F);
        tick(3);
        chk(func_out.ext_fault, 32'h0000_0000);
        rdc(INT_STAT_OFS, 32'h0000_0001);
        rdc(INT_STAT_OFS, 32'h0000_0000);
        tick(2);
        chk(irq, 32'h0000_0000);
        // Each reference has its own setting; both sources zero or add.
        for (int i = 0; i < NUM_REF; i++)
            apb(1'b1, REF_SET_OFS + 8'(4 * i), 32'h0000_0100 + i);
        tick(2);
        chk(ref_out[0], 32'h0000_0100);
        want[23:13] <= '1;
        tick(3);
        for (int i = 0; i < NUM_REF; i++) begin
            e = (i == 0) ? 0 : (i == 4) ? 32'h0000_0208 : 32'h0000_0100 + i;
            chk(ref_out[i], e);
        end
        rdc(REF_OUT_OFS + 8'h10, 32'h0000_0208);
        // Dropping serial valid freezes the last accepted word.
        apb(1'b1, STD_CW_OFS, 32'h0000_0000);
        apb(1'b1, SRC_CW_OFS, 32'h0000_0000);
        tick(3);
        chk(serial_ok, 32'h0000_0000);
        chk(func_out.ramp_set3, 32'h0000_0001);
        test_done();
    end
endmodule

/* ref_select.sv */
// Picks each jog, thread, fixed and additional reference value.
`timescale 1ns/100ps
module ref_select #(
    parameter int N      = 11,
    parameter int W      = 16,
    parameter int N_ZERO = 4
) (
    // Requests from both sources.
    input  wire logic [N-1:0]        term_req,
    input  wire logic [N-1:0]        ser_req,
    // Configured value of each function.
    input  wire logic [N-1:0][W-1:0] setting,
    // Resulting reference of each function and a both-source flag.
    output logic      [N-1:0][W:0]   ref_val,
    output logic                     conflict
);

    // Single request passes its setting; a double one zeroes or adds.
    always_comb begin
        conflict = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (term_req[i] && ser_req[i]) begin
                conflict = 1'b1;
                if (i < N_ZERO) begin
                    ref_val[i] = '0;
                end else begin
                    ref_val[i] = {1'b0, setting[i]} + {1'b0, setting[i]};
                end
            end else if (term_req[i] || ser_req[i]) begin
                ref_val[i] = {1'b0, setting[i]};
            end else begin
                ref_val[i] = '0;
            end
        end
    end

endmodule
